/* File: hw/pll_cfg_pkg.sv */
/*
 * Constants for the loop configuration, unlock key and status block.
 * Assumes a 32-bit APB slave port with byte addresses as printed.
 */
package pll_cfg_pkg;
   // register byte addresses
   localparam logic [31:0] ADDR_CONTROL_HOLDING = 32'hE01FC080;
   localparam logic [31:0] ADDR_CONFIG_HOLDING  = 32'hE01FC084;
   localparam logic [31:0] ADDR_STATUS_READBACK = 32'hE01FC088;
   localparam logic [31:0] ADDR_UNLOCK_KEY      = 32'hE01FC08C;

   // field widths and positions
   localparam int MULT_W        = 5;
   localparam int DIV_W         = 2;
   localparam int MULT_LSB      = 0;
   localparam int DIV_LSB       = 5;
   localparam int CTL_EN_BIT    = 0;
   localparam int CTL_CON_BIT   = 1;
   localparam int STAT_EN_BIT   = 8;
   localparam int STAT_CON_BIT  = 9;
   localparam int STAT_LOCK_BIT = 10;
   localparam int KEY_W         = 8;
   localparam int CFG_W         = 8;
   localparam int CTL_W         = 2;
   localparam int DATA_W        = 32;

   // unlock key values, first then second
   localparam logic [KEY_W-1:0] KEY_FIRST  = 8'hAA;
   localparam logic [KEY_W-1:0] KEY_SECOND = 8'h55;

   // reset values
   localparam logic [CFG_W-1:0]  CFG_RESET  = 8'h00;
   localparam logic [CTL_W-1:0]  CTL_RESET  = 2'h0;
   localparam logic [DATA_W-1:0] DATA_ZERO  = 32'h00000000;
   localparam logic [MULT_W-1:0] MULT_RESET = 5'h00;
   localparam logic [DIV_W-1:0]  DIV_RESET  = 2'h0;
endpackage

/* File: hw/lock_sync.sv */
/*
 * Two-flop level synchroniser.
 * Assumes the input is a level from another timing domain.
 */
`timescale 1ns/100ps
`default_nettype none
module lock_sync (
   input  wire logic clk_i,
   input  wire logic rstn_i,
   input  wire logic async_i,
   output logic      sync_o
);
   logic meta_q;
   logic sync_q;

   // first flop feeds only the second
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end
      else
      begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;
endmodule
`default_nettype wire

/* File: hw/pll_config_feed_status.sv */
/*
 * Loop configuration holding, unlock key sequence, active shadow values
 * and status readback, reached over an APB slave port.
 * Assumes APB signalling from one master, a lock level from the analog loop,
 * a power-down level from power control, and a glitch-free clock switch
 * downstream that follows core_clock_from_loop_o.
 */
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - config bits 4:0 hold multiplier minus one
// - config bits 6:5 select divide 1/2/4/8
// - config writes reach only holding copy
// - key 0xAA then 0x55 loads active values
// - bad key, order or gap: nothing loads
// - status bits 6:0 show active multiplier, divider
// - status bit 8 enable, cleared on power-down
// - status bit 9 connect, cleared on power-down
// - status bit 10 shows lock indicator
// - lock indicator drives interrupt source output
// - loop clock only when enable and connect
// - enable without connect runs loop, oscillator clock
// - power-down clears enable, connect; wake restores nothing
// - reserved bits read as zero
// - control bit 0 enable, bit 1 connect
// - reset leaves everything zero, loop off
// - clock select changes only from a flop
// - no lock check, no auto disconnect
module pll_config_feed_status (
   input  wire logic                        clk_i,
   input  wire logic                        rstn_i,
   input  wire logic                        psel_i,
   input  wire logic                        penable_i,
   input  wire logic                        pwrite_i,
   input  wire logic [31:0]                 paddr_i,
   input  wire logic [31:0]                 pwdata_i,
   output logic      [31:0]                 prdata_o,
   output logic                             pready_o,
   output logic                             pslverr_o,
   input  wire logic                        lock_indicator_i,
   input  wire logic                        power_down_i,
   output logic                             loop_enable_o,
   output logic                             loop_connect_o,
   output logic      [4:0]                  multiplier_select_o,
   output logic      [1:0]                  divider_select_o,
   output logic                             core_clock_from_loop_o,
   output logic                             lock_irq_o
);
   logic [pll_cfg_pkg::CFG_W-1:0]  cfg_q;
   logic [pll_cfg_pkg::CTL_W-1:0]  ctl_q;
   logic [pll_cfg_pkg::MULT_W-1:0] act_mult_q;
   logic [pll_cfg_pkg::DIV_W-1:0]  act_div_q;
   logic                           act_en_q;
   logic                           act_con_q;
   logic                           armed_q;
   logic                           pd_q;
   logic                           clk_sel_q;
   logic                           lock_irq_q;
   logic [pll_cfg_pkg::DATA_W-1:0] prdata_q;
   logic [pll_cfg_pkg::DATA_W-1:0] rdata_d;
   logic                           pready_q;
   logic                           pslverr_q;
   logic                           lock_s;
   logic                           setup;
   logic                           access;
   logic                           hit_ctl;
   logic                           hit_cfg;
   logic                           hit_stat;
   logic                           hit_key;
   logic                           key_first;
   logic                           key_second;
   logic                           feed_ok;
   logic                           pd_entry;

   assign setup    = psel_i && !penable_i;
   assign access   = psel_i && penable_i;
   assign hit_ctl  = (paddr_i == pll_cfg_pkg::ADDR_CONTROL_HOLDING);
   assign hit_cfg  = (paddr_i == pll_cfg_pkg::ADDR_CONFIG_HOLDING);
   assign hit_stat = (paddr_i == pll_cfg_pkg::ADDR_STATUS_READBACK);
   assign hit_key  = (paddr_i == pll_cfg_pkg::ADDR_UNLOCK_KEY);

   assign key_first  = access && pwrite_i && hit_key
                       && (pwdata_i[pll_cfg_pkg::KEY_W-1:0] == pll_cfg_pkg::KEY_FIRST);
   assign key_second = access && pwrite_i && hit_key
                       && (pwdata_i[pll_cfg_pkg::KEY_W-1:0] == pll_cfg_pkg::KEY_SECOND);
   assign feed_ok    = armed_q && key_second;
   assign pd_entry   = power_down_i && !pd_q;

   lock_sync u_lock_sync (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .async_i(lock_indicator_i),
      .sync_o (lock_s)
   );

   // holding registers; reserved bit 7 dropped on write so it reads zero
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cfg_q <= pll_cfg_pkg::CFG_RESET;
         ctl_q <= pll_cfg_pkg::CTL_RESET;
      end
      else if (access && pwrite_i)
      begin
         if (hit_cfg)
            cfg_q <= {1'b0, pwdata_i[pll_cfg_pkg::CFG_W-2:0]};
         if (hit_ctl)
            ctl_q <= pwdata_i[pll_cfg_pkg::CTL_W-1:0];
      end
   end

   // key detector: every completed transfer re-decides the armed state
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         armed_q <= 1'b0;
      else if (access)
         armed_q <= key_first;
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         pd_q <= 1'b0;
      else
         pd_q <= power_down_i;
   end

   // active values; power-down entry beats a feed in the same cycle
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         act_mult_q <= pll_cfg_pkg::MULT_RESET;
         act_div_q  <= pll_cfg_pkg::DIV_RESET;
         act_en_q   <= 1'b0;
         act_con_q  <= 1'b0;
      end
      else if (pd_entry)
      begin
         act_en_q  <= 1'b0;
         act_con_q <= 1'b0;
      end
      else if (feed_ok)
      begin
         act_mult_q <= cfg_q[pll_cfg_pkg::MULT_LSB +: pll_cfg_pkg::MULT_W];
         act_div_q  <= cfg_q[pll_cfg_pkg::DIV_LSB +: pll_cfg_pkg::DIV_W];
         act_en_q   <= ctl_q[pll_cfg_pkg::CTL_EN_BIT];
         act_con_q  <= ctl_q[pll_cfg_pkg::CTL_CON_BIT];
      end
   end

   // connect without enable stays on the oscillator; no lock check here
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         clk_sel_q <= 1'b0;
      else
         clk_sel_q <= act_en_q && act_con_q;
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         lock_irq_q <= 1'b0;
      else
         lock_irq_q <= lock_s;
   end

   always_comb
   begin
      rdata_d = pll_cfg_pkg::DATA_ZERO;
      if (hit_ctl)
      begin
         rdata_d[pll_cfg_pkg::CTL_EN_BIT]  = ctl_q[pll_cfg_pkg::CTL_EN_BIT];
         rdata_d[pll_cfg_pkg::CTL_CON_BIT] = ctl_q[pll_cfg_pkg::CTL_CON_BIT];
      end
      else if (hit_cfg)
         rdata_d[pll_cfg_pkg::CFG_W-1:0] = cfg_q;
      else if (hit_stat)
      begin
         rdata_d[pll_cfg_pkg::MULT_LSB +: pll_cfg_pkg::MULT_W] = act_mult_q;
         rdata_d[pll_cfg_pkg::DIV_LSB +: pll_cfg_pkg::DIV_W]   = act_div_q;
         rdata_d[pll_cfg_pkg::STAT_EN_BIT]   = act_en_q;
         rdata_d[pll_cfg_pkg::STAT_CON_BIT]  = act_con_q;
         rdata_d[pll_cfg_pkg::STAT_LOCK_BIT] = lock_s;
      end
   end

   // zero-wait slave: data captured in setup, presented in access
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         prdata_q  <= pll_cfg_pkg::DATA_ZERO;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end
      else
      begin
         pready_q  <= setup;
         pslverr_q <= setup && !(hit_ctl || hit_cfg || hit_stat || hit_key);
         if (setup)
            prdata_q <= rdata_d;
      end
   end

   assign prdata_o               = prdata_q;
   assign pready_o               = pready_q;
   assign pslverr_o              = pslverr_q;
   assign loop_enable_o          = act_en_q;
   assign loop_connect_o         = act_con_q;
   assign multiplier_select_o    = act_mult_q;
   assign divider_select_o       = act_div_q;
   assign core_clock_from_loop_o = clk_sel_q;
   assign lock_irq_o             = lock_irq_q;

   property p_hold_only;
      @(posedge clk_i) disable iff (!rstn_i)
      access && pwrite_i && hit_cfg |=> $stable(act_mult_q) && $stable(act_div_q);
   endproperty
   a_hold_only: assert property (p_hold_only) else $error("config write changed active value");

   property p_feed_load;
      @(posedge clk_i) disable iff (!rstn_i)
      feed_ok && !pd_entry |=> act_mult_q == $past(cfg_q[pll_cfg_pkg::MULT_LSB +: pll_cfg_pkg::MULT_W])
                               && act_div_q == $past(cfg_q[pll_cfg_pkg::DIV_LSB +: pll_cfg_pkg::DIV_W])
                               && act_en_q == $past(ctl_q[pll_cfg_pkg::CTL_EN_BIT])
                               && act_con_q == $past(ctl_q[pll_cfg_pkg::CTL_CON_BIT]);
   endproperty
   a_feed_load: assert property (p_feed_load) else $error("valid key did not load active values");

   property p_no_stray_load;
      @(posedge clk_i) disable iff (!rstn_i)
      $changed(act_mult_q) || $changed(act_div_q) || $rose(act_en_q) || $rose(act_con_q)
      |-> $past(feed_ok);
   endproperty
   a_no_stray_load: assert property (p_no_stray_load) else $error("active values changed without feed");

   property p_disarm;
      @(posedge clk_i) disable iff (!rstn_i)
      access && !key_first |=> !armed_q;
   endproperty
   a_disarm: assert property (p_disarm) else $error("key detector stayed armed");

   property p_status;
      @(posedge clk_i) disable iff (!rstn_i)
      setup && hit_stat |=> prdata_o[15:0] == {5'h00, $past(lock_s), $past(act_con_q), $past(act_en_q),
                                                1'b0, $past(act_div_q), $past(act_mult_q)};
   endproperty
   a_status: assert property (p_status) else $error("status readback wrong");

   property p_pd_clear;
      @(posedge clk_i) disable iff (!rstn_i)
      pd_entry |=> !act_en_q && !act_con_q ##1 !clk_sel_q;
   endproperty
   a_pd_clear: assert property (p_pd_clear) else $error("power-down did not clear loop");

   property p_lock_sync;
      @(posedge clk_i) disable iff (!rstn_i)
      lock_indicator_i [*2] |=> lock_s ##1 lock_irq_o;
   endproperty
   a_lock_sync: assert property (p_lock_sync) else $error("lock not seen two cycles after input");

   property p_clk_sel;
      @(posedge clk_i) disable iff (!rstn_i)
      1'b1 |=> core_clock_from_loop_o == ($past(act_en_q) && $past(act_con_q));
   endproperty
   a_clk_sel: assert property (p_clk_sel) else $error("clock select disagrees with enable and connect");

   c_feed: cover property (@(posedge clk_i) disable iff (!rstn_i) feed_ok && ctl_q == 2'h3);
   c_pd_active: cover property (@(posedge clk_i) disable iff (!rstn_i) pd_entry && act_en_q);
   c_broken_key: cover property (@(posedge clk_i) disable iff (!rstn_i)
                                 armed_q && access && !key_second);
endmodule
`default_nettype wire

/* File: test/apb_master.sv */
/*
 * APB master model standing in for processor software.
 * Assumes one slave whose pready is sampled on the rising edge of clk_i.
 */
`timescale 1ns/100ps
`default_nettype none
module apb_master (
   input  wire logic        clk_i,
   output logic             psel_o,
   output logic             penable_o,
   output logic             pwrite_o,
   output logic [31:0]      paddr_o,
   output logic [31:0]      pwdata_o,
   input  wire logic [31:0] prdata_i,
   input  wire logic        pready_i,
   input  wire logic        pslverr_i
);
   initial
   begin
      psel_o    = 1'b0;
      penable_o = 1'b0;
      pwrite_o  = 1'b0;
      paddr_o   = 32'h00000000;
      pwdata_o  = 32'h00000000;
   end

   // single caller process, so nothing can slip between two key writes
   task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata, output logic err, output logic hung);
      int n;
      n = 0;
      @(posedge clk_i);
      psel_o   <= 1'b1;
      pwrite_o <= wr;
      paddr_o  <= addr;
      pwdata_o <= wdata;
      @(posedge clk_i);
      penable_o <= 1'b1;
      @(posedge clk_i);
      while (pready_i !== 1'b1 && n < 8)
      begin
         @(posedge clk_i);
         n++;
      end
      hung  = (pready_i !== 1'b1);
      rdata = prdata_i;
      err   = pslverr_i;
      psel_o    <= 1'b0;
      penable_o <= 1'b0;
      // released bus must not keep showing the last value
      paddr_o   <= ~addr;
      pwdata_o  <= ~wdata;
   endtask
endmodule
`default_nettype wire

/* File: test/tb.sv */
/*
 * Self-checking bench for the loop configuration, key and status block.
 * Assumes apb_master as the bus partner and one 200 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none
module tb;
   localparam logic [31:0] A_CTL = pll_cfg_pkg::ADDR_CONTROL_HOLDING;
   localparam logic [31:0] A_CFG = pll_cfg_pkg::ADDR_CONFIG_HOLDING;
   localparam logic [31:0] A_STA = pll_cfg_pkg::ADDR_STATUS_READBACK;
   localparam logic [31:0] A_KEY = pll_cfg_pkg::ADDR_UNLOCK_KEY;
   logic        clk_i, rstn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, last_err;
   logic [31:0] paddr_i, pwdata_i, prdata_o;
   logic        lock_indicator_i, power_down_i, loop_enable_o, loop_connect_o;
   logic [4:0]  multiplier_select_o;
   logic [1:0]  divider_select_o;
   logic        core_clock_from_loop_o, lock_irq_o;
   int          error_cnt = 0;
   int          checked   = 0;

   pll_config_feed_status i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .lock_indicator_i(lock_indicator_i), .power_down_i(power_down_i),
      .loop_enable_o(loop_enable_o), .loop_connect_o(loop_connect_o), .multiplier_select_o(multiplier_select_o),
      .divider_select_o(divider_select_o), .core_clock_from_loop_o(core_clock_from_loop_o),
      .lock_irq_o(lock_irq_o));
   apb_master i_host (.clk_i(clk_i), .psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i),
      .paddr_o(paddr_i), .pwdata_o(pwdata_i), .prdata_i(prdata_o), .pready_i(pready_o), .pslverr_i(pslverr_o));

   initial
   begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic give_verdict;
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
      checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic chkb(input string name, input logic exp, input logic seen);
      chk(name, {31'h0, exp}, {31'h0, seen});
   endtask

   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      logic hung;
      i_host.xfer(wr, a, d, r, last_err, hung);
      if (hung !== 1'b0)
      begin
         error_cnt++;
         $display("BAD pready expected 1 seen 0");
         give_verdict();
      end
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] x;
      xfer(1'b1, a, d, x);
   endtask

   task automatic rd(input logic [31:0] a, output logic [31:0] r);
      xfer(1'b0, a, 32'h00000000, r);
   endtask

   task automatic feed(input logic [7:0] a, input logic [7:0] b);
      wr(A_KEY, {24'h0, a});
      wr(A_KEY, {24'h0, b});
   endtask

   task automatic load(input logic [31:0] cfg, input logic [31:0] ctl);
      wr(A_CFG, cfg);
      wr(A_CTL, ctl);
      feed(8'hAA, 8'h55);
      @(negedge clk_i);
   endtask

   task automatic chk_act(input logic [4:0] m, input logic [1:0] d, input logic en, input logic con,
                          input logic lk);
      logic [31:0] v;
      rd(A_STA, v);
      chk("status", {21'h0, lk, con, en, 1'b0, d, m}, v);
      chk("active", {23'h0, en, con, d, m},
          {23'h0, loop_enable_o, loop_connect_o, divider_select_o, multiplier_select_o});
   endtask

   task automatic lock_to(input logic lk);
      @(posedge clk_i);
      lock_indicator_i <= lk;
      repeat (6) @(posedge clk_i);
      chkb("irq", lk, lock_irq_o);
   endtask

   task automatic t_reset;
      logic [31:0] v;
      chk_act(5'h00, 2'h0, 1'b0, 1'b0, 1'b0);
      chkb("clk_sel", 1'b0, core_clock_from_loop_o);
      rd(A_CFG, v);
      chk("config", 32'h00000000, v);
      rd(A_CTL, v);
      chk("control", 32'h00000000, v);
      rd(A_KEY, v);
      chk("key", 32'h00000000, v);
   endtask

   task automatic t_hold;
      logic [31:0] v;
      wr(A_CFG, 32'hFFFFFFFF);
      wr(A_CTL, 32'hFFFFFFFF);
      wr(A_STA, 32'hFFFFFFFF);
      rd(A_CFG, v);
      chk("config", 32'h0000007F, v);
      rd(A_CTL, v);
      chk("control", 32'h00000003, v);
      chk_act(5'h00, 2'h0, 1'b0, 1'b0, 1'b0);
      rd(32'hE01FC090, v);
      chkb("unmapped_err", 1'b1, last_err);
      chk("unmapped", 32'h00000000, v);
   endtask

   task automatic t_codes;
      for (int d = 0; d < 4; d++)
         for (int k = 0; k < 2; k++)
         begin
            load({25'h0, d[1:0], k ? 5'h1F : 5'h00}, 32'h00000000);
            chk_act(k ? 5'h1F : 5'h00, d[1:0], 1'b0, 1'b0, 1'b0);
         end
   endtask

   task automatic t_bad;
      load(32'h00000025, 32'h00000000);
      wr(A_CFG, 32'h0000001F);
      feed(8'hAA, 8'h56);
      chk_act(5'h05, 2'h1, 1'b0, 1'b0, 1'b0);
      feed(8'h55, 8'hAA);
      wr(A_CTL, 32'h00000000);
      wr(A_KEY, 32'h00000055);
      chk_act(5'h05, 2'h1, 1'b0, 1'b0, 1'b0);
      wr(A_KEY, 32'h000000AA);
      chk_act(5'h05, 2'h1, 1'b0, 1'b0, 1'b0);
      wr(A_KEY, 32'h00000055);
      chk_act(5'h05, 2'h1, 1'b0, 1'b0, 1'b0);
      feed(8'hAA, 8'hAA);
      wr(A_KEY, 32'h00000055);
      chk_act(5'h1F, 2'h0, 1'b0, 1'b0, 1'b0);
   endtask

   task automatic t_modes;
      load(32'h00000025, 32'h00000002);
      chk_act(5'h05, 2'h1, 1'b0, 1'b1, 1'b0);
      chkb("clk_sel", 1'b0, core_clock_from_loop_o);
      load(32'h00000025, 32'h00000001);
      chk_act(5'h05, 2'h1, 1'b1, 1'b0, 1'b0);
      chkb("clk_sel", 1'b0, core_clock_from_loop_o);
      lock_to(1'b1);
      chk_act(5'h05, 2'h1, 1'b1, 1'b0, 1'b1);
      load(32'h00000025, 32'h00000003);
      chkb("clk_sel", 1'b0, core_clock_from_loop_o);
      @(negedge clk_i);
      chkb("clk_sel", 1'b1, core_clock_from_loop_o);
      lock_to(1'b0);
      chk_act(5'h05, 2'h1, 1'b1, 1'b1, 1'b0);
      chkb("clk_sel", 1'b1, core_clock_from_loop_o);
   endtask

   task automatic t_pd;
      logic [31:0] v;
      @(posedge clk_i);
      power_down_i <= 1'b1;
      repeat (3) @(negedge clk_i);
      chkb("clk_sel", 1'b0, core_clock_from_loop_o);
      chk_act(5'h05, 2'h1, 1'b0, 1'b0, 1'b0);
      @(posedge clk_i);
      power_down_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk_act(5'h05, 2'h1, 1'b0, 1'b0, 1'b0);
      rd(A_CTL, v);
      chk("control", 32'h00000003, v);
      // wake: enable, await lock, then connect
      load(32'h00000025, 32'h00000001);
      lock_to(1'b1);
      load(32'h00000025, 32'h00000003);
      chk_act(5'h05, 2'h1, 1'b1, 1'b1, 1'b1);
   endtask

   initial
   begin
      rstn_i           = 1'b0;
      lock_indicator_i = 1'b0;
      power_down_i     = 1'b0;
      repeat (5) @(posedge clk_i);
      rstn_i <= 1'b1;
      t_reset();
      t_hold();
      t_codes();
      t_bad();
      t_modes();
      t_pd();
      give_verdict();
   end
endmodule
`default_nettype wire
